// >>> hw/bstap_pkg.sv
// package of constants and types for the boundary scan test access port
// assumes a single test clock domain plus a system clock for status
package bstap_pkg;

   // =====================================================================
   // register widths
   localparam int unsigned IR_W   = 8;
   localparam int unsigned BCC_W  = 40;
   localparam int unsigned SCC_W  = 11;

   // =====================================================================
   // reset and capture values
   localparam logic [IR_W-1:0]  IR_RESET      = 8'hff;
   localparam logic [IR_W-1:0]  IR_CAPTURE    = 8'h81;
   localparam logic [BCC_W-1:0] BCC_RESET     = 40'h00_0000_0000;
   localparam logic [SCC_W-1:0] SCC_RESET     = 11'h002;
   localparam logic             BYPASS_CAPT   = 1'b0;

   // =====================================================================
   // opcodes, bypass is all ones and anything unknown falls to bypass
   localparam logic [IR_W-1:0]  OP_BYPASS     = 8'hff;
   localparam logic [IR_W-1:0]  OP_EXTEST     = 8'h00;
   localparam logic [IR_W-1:0]  OP_SAMPLE     = 8'h82;
   localparam logic [IR_W-1:0]  OP_SCANCTRL   = 8'h87;
   localparam logic [IR_W-1:0]  OP_RUNT       = 8'h09;

   // =====================================================================
   // scan control chain mode field
   localparam int unsigned      SCC_MODE_LSB  = 0;
   localparam int unsigned      SCC_MODE_W    = 3;
   localparam logic [2:0]       SCC_MODE_PSA  = 3'h2;

   // signature feedback taps of the boundary cell chain
   localparam int unsigned      PSA_TAP_A     = 39;
   localparam int unsigned      PSA_TAP_B     = 20;

   // =====================================================================
   // selected data register
   typedef enum logic [1:0] {
      BSTAP_DR_BYPASS = 2'h0,
      BSTAP_DR_BCC    = 2'h1,
      BSTAP_DR_SCC    = 2'h2
   } bstap_dr_t;

   // controller states, one hot
   typedef enum logic [15:0] {
      ST_TLR  = 16'h0001,
      ST_RTI  = 16'h0002,
      ST_SDR  = 16'h0004,
      ST_CDR  = 16'h0008,
      ST_SHDR = 16'h0010,
      ST_E1DR = 16'h0020,
      ST_PDR  = 16'h0040,
      ST_E2DR = 16'h0080,
      ST_UDR  = 16'h0100,
      ST_SIR  = 16'h0200,
      ST_CIR  = 16'h0400,
      ST_SHIR = 16'h0800,
      ST_E1IR = 16'h1000,
      ST_PIR  = 16'h2000,
      ST_E2IR = 16'h4000,
      ST_UIR  = 16'h8000
   } bstap_state_t;

endpackage : bstap_pkg

// >>> hw/bstap_top.sv
// test access port controller with instruction, boundary cell,
// scan control and bypass registers
// assumes the tester drives i_tck, i_tms, i_tdi; tdo pin resolved outside
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - test inputs sampled on rising test clock, outputs change on falling edge
// - serial in feeds and serial out drains whichever register is in the path
// - state advances on mode select level at each rising test clock edge
// - sixteen states, six stable, ten left after one cycle
// - eight bit instruction, forty bit boundary, eleven bit control, one bit bypass
// - separate data and instruction scan paths, only one connected at a time
// - start in logic reset, test logic disabled while held there
// - mode select high for five clocks reaches logic reset from anywhere
// - logic reset loads instruction register with all ones, bypass
// - logic reset clears every boundary cell to zero
// - logic reset loads control chain with signature mode, no masking
// - control chain operation runs only while in run-test/idle
// - select states do nothing and leave after one cycle
// - selected boundary or bypass register captures on edge leaving capture-dr, control chain holds
// - shift-dr entry enables serial out with lsb at first falling edge
// - shift once per clock, first after entry, last on exit edge
// - serial out returns to high impedance at falling edge in exit1
// - data shadow loads from shift stage at falling edge in update-dr
// - new instruction takes effect at falling edge in update-ir
// - capture-ir loads fixed status pattern into instruction shift stage
module bstap_top
(
   // system clock and reset
   input  wire  logic                        i_mclk,
   input  wire  logic                        i_rstn,
   // test port
   input  wire  logic                        i_tck,
   input  wire  logic                        i_tms,
   input  wire  logic                        i_tdi,
   output var   logic                        o_tdo,
   output var   logic                        o_tdo_oe,
   // boundary pins observed and driven
   input  wire  logic [bstap_pkg::BCC_W-1:0] i_pins,
   output var   logic [bstap_pkg::BCC_W-1:0] o_bcc_out,
   output var   logic [bstap_pkg::SCC_W-1:0] o_scc_out,
   output var   logic [bstap_pkg::IR_W-1:0]  o_instr,
   output var   logic                        o_test_mode,
   // status in system clock domain
   output var   logic                        o_logic_reset,
   output var   logic                        o_run_active
);
   import bstap_pkg::*;

   // ======================================================================
   // reset release, one copy per clock domain
   logic [1:0] mrst_q;
   logic [1:0] trst_q;
   logic       mrstn;
   logic       trstn;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) mrst_q <= 2'h0;
      else         mrst_q <= {mrst_q[0], 1'b1};
   end

   // the test clock may stop, so it gets its own release chain
   always_ff @(posedge i_tck or negedge i_rstn) begin
      if (!i_rstn) trst_q <= 2'h0;
      else         trst_q <= {trst_q[0], 1'b1};
   end

   assign mrstn = mrst_q[1];
   assign trstn = trst_q[1];

   // ======================================================================
   // controller state machine
   bstap_state_t state_q;
   bstap_state_t state_d;

   function automatic bstap_state_t next_state(input bstap_state_t s, input logic m);
      case (s)
         ST_TLR:  next_state = m ? ST_TLR  : ST_RTI;
         ST_RTI:  next_state = m ? ST_SDR  : ST_RTI;
         ST_SDR:  next_state = m ? ST_SIR  : ST_CDR;
         ST_CDR:  next_state = m ? ST_E1DR : ST_SHDR;
         ST_SHDR: next_state = m ? ST_E1DR : ST_SHDR;
         ST_E1DR: next_state = m ? ST_UDR  : ST_PDR;
         ST_PDR:  next_state = m ? ST_E2DR : ST_PDR;
         ST_E2DR: next_state = m ? ST_UDR  : ST_SHDR;
         ST_UDR:  next_state = m ? ST_SDR  : ST_RTI;
         ST_SIR:  next_state = m ? ST_TLR  : ST_CIR;
         ST_CIR:  next_state = m ? ST_E1IR : ST_SHIR;
         ST_SHIR: next_state = m ? ST_E1IR : ST_SHIR;
         ST_E1IR: next_state = m ? ST_UIR  : ST_PIR;
         ST_PIR:  next_state = m ? ST_E2IR : ST_PIR;
         ST_E2IR: next_state = m ? ST_UIR  : ST_SHIR;
         ST_UIR:  next_state = m ? ST_SDR  : ST_RTI;
         default: next_state = ST_TLR;
      endcase
   endfunction : next_state

   assign state_d = next_state(state_q, i_tms);

   // every state has a mode select exit toward logic reset
   always_ff @(posedge i_tck or negedge trstn) begin
      if (!trstn) state_q <= ST_TLR;
      else        state_q <= state_d;
   end

   // ======================================================================
   // instruction decode of the active instruction
   logic [IR_W-1:0] ir_q;
   logic [IR_W-1:0] ir_sh_q;
   bstap_dr_t       dr_sel;
   logic            is_runt;
   logic [IR_W-1:0] ir_upd;

   function automatic bstap_dr_t dr_of(input logic [IR_W-1:0] op);
      case (op)
         OP_EXTEST, OP_SAMPLE: dr_of = BSTAP_DR_BCC;
         OP_SCANCTRL:          dr_of = BSTAP_DR_SCC;
         default:              dr_of = BSTAP_DR_BYPASS;
      endcase
   endfunction : dr_of

   assign dr_sel  = dr_of(ir_q);
   assign is_runt = (ir_q == OP_RUNT);
   assign ir_upd  = (state_q == ST_UIR) ? ir_sh_q : ir_q; // mode must not lag update-ir

   // ======================================================================
   // pin sampling, pins are asynchronous to the test clock
   logic [BCC_W-1:0] pins_m_q;
   logic [BCC_W-1:0] pins_s_q;

   always_ff @(posedge i_tck or negedge trstn) begin
      if (!trstn) begin
         pins_m_q <= BCC_RESET;
         pins_s_q <= BCC_RESET;
      end else begin
         pins_m_q <= i_pins;
         pins_s_q <= pins_m_q;
      end
   end

   // ======================================================================
   // shift stages, all moving on the rising edge
   logic [BCC_W-1:0] boundary_cell_chain_q;
   logic [BCC_W-1:0] boundary_cell_chain_d;
   logic [SCC_W-1:0] scan_control_chain_q;
   logic [SCC_W-1:0] scan_control_chain_d;
   logic [IR_W-1:0]  ir_sh_d;
   logic             bypass_q;
   logic             bypass_d;
   logic             in_tlr;
   logic             cap_dr;
   logic             sh_dr;
   logic             psa_run;
   logic [SCC_W-1:0] scc_sh_q;
   logic [BCC_W-1:0] psa_next;

   assign in_tlr  = (state_q == ST_TLR);
   assign cap_dr  = (state_q == ST_CDR);
   assign sh_dr   = (state_q == ST_SHDR);
   // signature compression only runs in idle under the run instruction
   assign psa_run = (state_q == ST_RTI) && is_runt &&
                    (scc_sh_q[SCC_MODE_LSB +: SCC_MODE_W] == SCC_MODE_PSA);
   assign psa_next = {boundary_cell_chain_q[BCC_W-2:0],
                      boundary_cell_chain_q[PSA_TAP_A] ^ boundary_cell_chain_q[PSA_TAP_B]}
                     ^ pins_s_q;

   // boundary cell chain, lsb leaves first
   assign boundary_cell_chain_d =
      in_tlr                            ? BCC_RESET :
      (cap_dr && dr_sel == BSTAP_DR_BCC) ? pins_s_q :
      (sh_dr  && dr_sel == BSTAP_DR_BCC) ? {i_tdi, boundary_cell_chain_q[BCC_W-1:1]} :
      psa_run                           ? psa_next :
      boundary_cell_chain_q;

   // control chain keeps its contents through capture
   assign scan_control_chain_d =
      in_tlr                            ? SCC_RESET :
      (sh_dr && dr_sel == BSTAP_DR_SCC)  ? {i_tdi, scan_control_chain_q[SCC_W-1:1]} :
      scan_control_chain_q;

   assign bypass_d =
      (cap_dr && dr_sel == BSTAP_DR_BYPASS) ? BYPASS_CAPT :
      (sh_dr  && dr_sel == BSTAP_DR_BYPASS) ? i_tdi :
      bypass_q;

   assign ir_sh_d =
      (state_q == ST_CIR)  ? IR_CAPTURE :
      (state_q == ST_SHIR) ? {i_tdi, ir_sh_q[IR_W-1:1]} :
      ir_sh_q;

   // rising edge sampling of the serial input
   always_ff @(posedge i_tck or negedge trstn) begin
      if (!trstn) begin
         boundary_cell_chain_q <= BCC_RESET;
         scan_control_chain_q  <= SCC_RESET;
         bypass_q              <= BYPASS_CAPT;
         ir_sh_q               <= IR_RESET;
      end else begin
         boundary_cell_chain_q <= boundary_cell_chain_d;
         scan_control_chain_q  <= scan_control_chain_d;
         bypass_q              <= bypass_d;
         ir_sh_q               <= ir_sh_d;
      end
   end

   // ======================================================================
   // falling edge outputs: serial out, enable and shadow latches
   logic tdo_d;

   assign tdo_d = (state_q == ST_SHIR)          ? ir_sh_q[0] :
                  (dr_sel == BSTAP_DR_BCC)      ? boundary_cell_chain_q[0] :
                  (dr_sel == BSTAP_DR_SCC)      ? scan_control_chain_q[0] :
                  bypass_q;

   always_ff @(negedge i_tck or negedge trstn) begin
      if (!trstn) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else begin
         o_tdo    <= tdo_d;
         o_tdo_oe <= (state_q == ST_SHDR) || (state_q == ST_SHIR);
      end
   end

   // shadows change only on the falling edge so outputs settle mid cycle
   always_ff @(negedge i_tck or negedge trstn) begin
      if (!trstn) begin
         ir_q     <= IR_RESET;
         scc_sh_q <= SCC_RESET;
      end else if (in_tlr) begin
         ir_q     <= IR_RESET;
         scc_sh_q <= SCC_RESET;
      end else begin
         if (state_q == ST_UIR) ir_q <= ir_sh_q;
         if (state_q == ST_UDR && dr_sel == BSTAP_DR_SCC) scc_sh_q <= scan_control_chain_q;
      end
   end

   always_ff @(negedge i_tck or negedge trstn) begin
      if (!trstn)      o_bcc_out <= BCC_RESET;
      else if (in_tlr) o_bcc_out <= BCC_RESET;
      else if (state_q == ST_UDR && dr_sel == BSTAP_DR_BCC)
                       o_bcc_out <= boundary_cell_chain_q;
   end

   assign o_scc_out = scc_sh_q;
   assign o_instr   = ir_q;

   // test mode only while the extest instruction is active, not under sample
   always_ff @(negedge i_tck or negedge trstn) begin
      if (!trstn) o_test_mode <= 1'b0;
      else        o_test_mode <= !in_tlr && (ir_upd == OP_EXTEST);
   end

   // ======================================================================
   // status levels toward the system clock
   logic tlr_q;
   logic run_q;

   always_ff @(posedge i_tck or negedge trstn) begin
      if (!trstn) begin
         tlr_q <= 1'b1;
         run_q <= 1'b0;
      end else begin
         tlr_q <= (state_d == ST_TLR);
         run_q <= (state_d == ST_RTI) && is_runt;
      end
   end

   // two flip-flop crossing of slow levels
   logic [1:0] tlr_sync_q;
   logic [1:0] run_sync_q;

   always_ff @(posedge i_mclk or negedge mrstn) begin
      if (!mrstn) begin
         tlr_sync_q <= 2'h3;
         run_sync_q <= 2'h0;
      end else begin
         tlr_sync_q <= {tlr_sync_q[0], tlr_q};
         run_sync_q <= {run_sync_q[0], run_q};
      end
   end

   always_ff @(posedge i_mclk or negedge mrstn) begin
      if (!mrstn) begin
         o_logic_reset <= 1'b1;
         o_run_active  <= 1'b0;
      end else begin
         o_logic_reset <= tlr_sync_q[1];
         o_run_active  <= run_sync_q[1];
      end
   end

   // ======================================================================
   // checks in the test clock domain
   property p_tlr_five;
      @(posedge i_tck) disable iff (!trstn)
      i_tms [*5] |=> (state_q == ST_TLR);
   endproperty
   a_tlr_five: assert property (p_tlr_five) else $error("tms high did not reach reset");

   property p_ir_reset;
      @(posedge i_tck) disable iff (!trstn)
      (state_q == ST_TLR) |=> (ir_q == IR_RESET) && (o_bcc_out == BCC_RESET);
   endproperty
   a_ir_reset: assert property (p_ir_reset) else $error("reset values not loaded");

   property p_scc_reset;
      @(posedge i_tck) disable iff (!trstn)
      (state_q == ST_TLR) |=> (scan_control_chain_q == SCC_RESET);
   endproperty
   a_scc_reset: assert property (p_scc_reset) else $error("control chain not reset");

   property p_cap_ir;
      @(posedge i_tck) disable iff (!trstn)
      (state_q == ST_CIR) |=> (ir_sh_q == IR_CAPTURE);
   endproperty
   a_cap_ir: assert property (p_cap_ir) else $error("status pattern not captured");

   property p_shift_ir;
      @(posedge i_tck) disable iff (!trstn)
      (state_q == ST_SHIR) |=> (ir_sh_q == {$past(i_tdi), $past(ir_sh_q[IR_W-1:1])});
   endproperty
   a_shift_ir: assert property (p_shift_ir) else $error("instruction shift wrong");

   property p_tdo_on;
      @(posedge i_tck) disable iff (!trstn)
      (state_q == ST_SHDR) |-> o_tdo_oe && (o_tdo == tdo_d);
   endproperty
   a_tdo_on: assert property (p_tdo_on) else $error("serial out not driven in shift");

   sequence s_exit1;
      (state_q == ST_SHDR) ##1 (state_q == ST_E1DR);
   endsequence
   property p_tdo_off;
      @(posedge i_tck) disable iff (!trstn)
      s_exit1 |=> !o_tdo_oe;
   endproperty
   a_tdo_off: assert property (p_tdo_off) else $error("serial out not released");

   property p_bypass;
      @(posedge i_tck) disable iff (!trstn)
      (cap_dr && dr_sel == BSTAP_DR_BYPASS) |=> (bypass_q == BYPASS_CAPT);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass did not capture zero");

   property p_select;
      @(posedge i_tck) disable iff (!trstn)
      (state_q == ST_SDR) |=> (state_q == ST_CDR) || (state_q == ST_SIR);
   endproperty
   a_select: assert property (p_select) else $error("select state not left");

   property p_cap_bcc;
      @(posedge i_tck) disable iff (!trstn)
      (cap_dr && dr_sel == BSTAP_DR_BCC) |=> (boundary_cell_chain_q == $past(pins_s_q));
   endproperty
   a_cap_bcc: assert property (p_cap_bcc) else $error("boundary capture wrong");

   property p_mode;
      @(posedge i_tck) disable iff (!trstn)
      (state_q == ST_UIR) |-> (o_test_mode == (ir_q == OP_EXTEST));
   endproperty
   a_mode: assert property (p_mode) else $error("mode change late");

endmodule : bstap_top

`default_nettype wire

// >>> verification/bstap_tester.sv
// behavioural model of the external test bus controller for the tap block
// assumes the tap samples on rising tck and drives tdo on falling tck
`timescale 1ns/100ps
`default_nettype none

module bstap_tester (
   // test port towards the device
   output var logic o_tck,
   output var logic o_tms,
   output var logic o_tdi,
   // serial return from the device
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   // =====================================================================
   // clock pulses
   // tck only runs inside frames, so it stands still between calls
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end

   // one 80 ns tck period, inputs settled a half period before the edge
   task automatic tick(input logic tms_v, input logic tdi_v,
                       output logic tdo_v, output logic oe_v);
      o_tms = tms_v;
      o_tdi = tdi_v;
      #40;
      tdo_v = i_tdo_oe ? i_tdo : ~i_tdo; // released pin has no pull, show the inverse
      oe_v  = i_tdo_oe;
      o_tck = 1'b1;
      #40;
      o_tck = 1'b0;
   endtask : tick

   // repeated ticks at one mode select level, used for reset and idle
   task automatic idle(input int n, input logic tms_v);
      logic d;
      logic e;
      for (int i = 0; i < n; i++) begin
         tick(tms_v, 1'b1, d, e);
      end
   endtask : idle

   // =====================================================================
   // full scan from run-test/idle and back there
   // returns the bits seen lsb first and whether the drive enable misbehaved
   task automatic scan(input bit ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout, output logic oe_bad);
      logic d;
      logic e;
      dout   = '0;
      oe_bad = 1'b0;
      #3.3; // phase offset against the system clock
      tick(1'b1, 1'b1, d, e);
      if (ir) begin
         tick(1'b1, 1'b1, d, e);
      end
      tick(1'b0, 1'b1, d, e);
      tick(1'b0, 1'b1, d, e);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], d, e);
         dout[i] = d;
         if (e !== 1'b1) oe_bad = 1'b1;
      end
      tick(1'b1, 1'b1, d, e);
      if (e !== 1'b0) oe_bad = 1'b1;
      tick(1'b0, 1'b1, d, e);
   endtask : scan
endmodule : bstap_tester

`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the tap controller
// assumes the tester model drives the test port and the bench the pins
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import bstap_pkg::*;

   // =====================================================================
   // signals
   logic                 i_mclk;
   logic                 i_rstn;
   logic [BCC_W-1:0]     i_pins;
   wire  logic           tck;
   wire  logic           tms;
   wire  logic           tdi;
   logic                 o_tdo;
   logic                 o_tdo_oe;
   logic [BCC_W-1:0]     o_bcc_out;
   logic [SCC_W-1:0]     o_scc_out;
   logic [IR_W-1:0]      o_instr;
   logic                 o_test_mode;
   logic                 o_logic_reset;
   logic                 o_run_active;
   int                   err_count;
   int                   n_tests;
   logic [31:0]          rng;
   logic [63:0]          dout;
   logic [63:0]          din;
   logic [63:0]          pv;
   logic                 bad;
   logic [IR_W-1:0]      ops [2];

   bstap_top i_dut (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pins(i_pins), .o_bcc_out(o_bcc_out),
      .o_scc_out(o_scc_out), .o_instr(o_instr), .o_test_mode(o_test_mode),
      .o_logic_reset(o_logic_reset), .o_run_active(o_run_active));

   bstap_tester i_tester (
      .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));

   // =====================================================================
   // clock, random source, checking
   initial i_mclk = 1'b0;
   always #5 i_mclk = ~i_mclk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // two draws give a 64 bit word
   task automatic draw(output logic [63:0] v);
      rng = xs(rng);
      v[31:0] = rng;
      rng = xs(rng);
      v[63:32] = rng;
   endtask : draw

   task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // status outputs cross into the system clock, so give them time to land
   task automatic settle();
      repeat (8) @(posedge i_mclk);
   endtask : settle

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   // cuts a hang short; the whole run needs well under this
   initial begin
      #200us;
      err_count++;
      $display("[FAIL] watchdog expired");
      final_report();
   end

   // =====================================================================
   // main sequence
   initial begin
      err_count = 0;
      n_tests   = 0;
      rng       = 32'h0001_2046;
      i_rstn    = 1'b0;
      i_pins    = '0;
      ops[0]    = OP_BYPASS;
      ops[1]    = 8'h5a; // not a defined opcode, must act as bypass
      i_tester.idle(2, 1'b1);
      @(posedge i_mclk);
      i_rstn <= 1'b1;
      i_tester.idle(3, 1'b1);
      settle();
      check("logic_reset", o_logic_reset, 1);
      check("instr_rst", o_instr, IR_RESET);
      check("bcc_rst", o_bcc_out, 0);
      check("scc_rst", o_scc_out, SCC_RESET);
      check("oe_idle", o_tdo_oe, 0);
      i_tester.idle(1, 1'b0);
      settle();
      check("left_reset", o_logic_reset, 0);
      $display("test reset done");

      // bypass and an undefined opcode, random data through one stage
      foreach (ops[k]) begin
         i_tester.scan(1'b1, 8, {56'h0, ops[k]}, dout, bad);
         check("ir_capture", dout[7:0], IR_CAPTURE);
         check("ir_oe", bad, 0);
         check("instr", o_instr, ops[k]);
         draw(din);
         i_tester.scan(1'b0, 8, din, dout, bad);
         check("bypass", dout[7:0], {din[6:0], 1'b0});
         check("dr_oe", bad, 0);
      end
      $display("test bypass done");

      // control chain: update shadow, capture leaves the shift stage alone
      i_tester.scan(1'b1, 8, {56'h0, OP_SCANCTRL}, dout, bad);
      draw(pv);
      i_tester.scan(1'b0, 11, pv, dout, bad);
      check("scc_update", o_scc_out, pv[10:0]);
      draw(din);
      i_tester.scan(1'b0, 11, din, dout, bad);
      check("scc_keep", dout[10:0], pv[10:0]);
      $display("test control chain done");

      // sample the pins, 41 bits prove a 40 bit chain
      draw(pv);
      @(posedge i_mclk);
      i_pins <= pv[39:0];
      i_tester.idle(3, 1'b0);
      i_tester.scan(1'b1, 8, {56'h0, OP_SAMPLE}, dout, bad);
      check("sample_mode", o_test_mode, 0);
      draw(din);
      i_tester.scan(1'b0, 41, din, dout, bad);
      check("bcc_capture", dout[39:0], pv[39:0]);
      check("bcc_len", dout[40], din[0]);
      $display("test sample done");

      // drive the boundary, then five ones from mid-scan force reset
      i_tester.scan(1'b1, 8, {56'h0, OP_EXTEST}, dout, bad);
      check("extest_mode", o_test_mode, 1);
      draw(din);
      i_tester.scan(1'b0, 40, din, dout, bad);
      check("bcc_update", o_bcc_out, din[39:0]);
      i_tester.idle(1, 1'b1);
      i_tester.idle(2, 1'b0);
      i_tester.idle(5, 1'b1);
      settle();
      check("tms_reset", o_logic_reset, 1);
      check("instr_tlr", o_instr, IR_RESET);
      check("bcc_tlr", o_bcc_out, 0);
      check("scc_tlr", o_scc_out, SCC_RESET);
      check("mode_tlr", o_test_mode, 0);
      $display("test forced reset done");

      // control chain operation only while held in run-test/idle
      i_tester.idle(1, 1'b0);
      i_tester.scan(1'b1, 8, {56'h0, OP_RUNT}, dout, bad);
      i_tester.idle(2, 1'b0);
      settle();
      check("run_active", o_run_active, 1);
      i_tester.idle(1, 1'b1);
      settle();
      check("run_stop", o_run_active, 0);
      $display("test run done");
      final_report();
   end
endmodule : tb_top

`default_nettype wire
